// ### logic/touch_key_sense_control.sv
`timescale 1ns/1ps
`include "touch_key_consts.svh"
module touch_key_sense_control
    import touch_key_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire reg_req_t   reg_req_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic       sense_tick_i,
    input  wire logic [63:0] sense_level_i,
    input  wire logic       warm_rst_i,
    input  wire logic       fifo_irq_clear_i,
    output logic            fifo_irq_o,
    output logic            system_irq_group_o,
    output logic            low_power_o,
    output logic [6:0]      range_shift_o,
    output logic [7:0]      touch_state_o
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] strongest(input chan_byte_t s, input logic [7:0] elig);
        logic [2:0] idx;
        logic [7:0] best;
        idx  = 3'h0;
        best = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (elig[i] && (s[i] > best || best == 8'h00)) begin
                best = s[i];
                idx  = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
        return r.wr && r.addr == a;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] filter_mode_select_reg;
    logic [7:0] recal_wait_time_reg;
    logic [7:0] recal_interval_reg;
    logic [7:0] integration_length_reg;
    logic [7:0] sense_control_reg;
    logic [7:0] touch_irq_mask_reg;
    logic [7:0] touch_irq_clear_reg;
    logic [7:0] second_filter_samples_reg;
    logic [7:0] second_filter_limit_reg;
    logic [6:0] range_shift_capacitance_reg;
    logic [6:0] ambient_variance_reg;
    logic [6:0] channel_touch_variance_reg [8];
    chan_byte_t channel_valid_touch_limit_reg;
    chan_byte_t channel_exceed_count_reg;
    chan_byte_t channel_reference_level_reg;
    chan_byte_t channel_live_level_reg;
    chan_byte_t exceed_acc_reg;
    chan_byte_t filter_cnt_reg;
    logic       eoc_pending_reg;
    logic       fifo_irq_reg;
    logic [6:0] range_shift_reg;
    logic [7:0] touch_state_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] integ_cnt_reg;
    logic [15:0] quiet_cnt_reg;
    logic [15:0] interval_cnt_reg;
    logic [7:0] fifo_mem [4];
    logic [1:0] fifo_wr_reg;
    logic [1:0] fifo_rd_reg;
    logic [2:0] fifo_cnt_reg;
    cal_state_t cal_state_reg;
    cal_state_t cal_state_next;

    logic       hold;
    logic       integ_end;
    logic [7:0] raw_touch;
    logic [7:0] afs_touch;
    logic [7:0] result_touch;
    logic [2:0] first_idx;
    logic [2:0] second_idx;
    logic       no_touch;
    logic       quiet_done;
    logic       interval_done;
    logic       auto_cal;
    logic       host_cal;
    logic       eoc_event;
    logic       fifo_push;
    logic       fifo_pop;
    logic [15:0] wait_ticks;
    logic [15:0] interval_ticks;

    assign hold = sense_control_reg[`BIT_HOLD];

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filter_mode_select_reg    <= `RST_FILTER_MODE;
            recal_wait_time_reg       <= `RST_WAIT_TIME;
            recal_interval_reg        <= `RST_INTERVAL;
            integration_length_reg    <= `RST_INTEGRATION;
            touch_irq_mask_reg        <= `RST_IRQ_MASK;
            touch_irq_clear_reg       <= `RST_ZERO;
            second_filter_samples_reg <= `RST_ZERO;
            second_filter_limit_reg   <= `RST_ZERO;
            range_shift_capacitance_reg <= 7'h00;
            ambient_variance_reg      <= `RST_AMBIENT_VAR;
            for (int i = 0; i < 8; i++) begin
                channel_touch_variance_reg[i]    <= `RST_VARIANCE;
                channel_valid_touch_limit_reg[i] <= `RST_LIMIT;
            end
        end else if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                `OFS_FILTER_MODE:  filter_mode_select_reg <= {5'h00, reg_req_i.wdata[2:0]};
                `OFS_WAIT_TIME:    recal_wait_time_reg <= reg_req_i.wdata;
                `OFS_INTERVAL:     recal_interval_reg <= reg_req_i.wdata;
                `OFS_INTEGRATION:  integration_length_reg <= reg_req_i.wdata;
                `OFS_IRQ_MASK:     touch_irq_mask_reg <= reg_req_i.wdata & `RST_IRQ_MASK;
                `OFS_IRQ_CLEAR:    touch_irq_clear_reg <= reg_req_i.wdata & `RST_IRQ_MASK;
                `OFS_FILT_SAMPLES: second_filter_samples_reg <= reg_req_i.wdata;
                `OFS_FILT_LIMIT:   second_filter_limit_reg <= reg_req_i.wdata;
                `OFS_RANGE_SHIFT:  range_shift_capacitance_reg <= reg_req_i.wdata[6:0];
                `OFS_AMBIENT_VAR:  ambient_variance_reg <= reg_req_i.wdata[6:0];
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (reg_req_i.addr == `OFS_VARIANCE_BASE + 8'(i))
                            channel_touch_variance_reg[i] <= reg_req_i.wdata[6:0];
                        if (reg_req_i.addr == `OFS_LIMIT_BASE + 8'(i))
                            channel_valid_touch_limit_reg[i] <= reg_req_i.wdata;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Control register with self-clearing bits
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sense_control_reg <= `RST_ZERO;
        end else if (wr_hit(reg_req_i, `OFS_SENSE_CTRL)) begin
            sense_control_reg <= {4'h0, reg_req_i.wdata[3:0]};
        end else if (cal_state_reg == CAL_DONE) begin
            sense_control_reg[`BIT_HOST_UNCOND] <= 1'b0;
            sense_control_reg[`BIT_HOST_COND]   <= 1'b0;
        end
    end

    // ****************************************
    // Range shift applied at warm reset
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            range_shift_reg <= 7'h00;
        end else if (warm_rst_i) begin
            range_shift_reg <= range_shift_capacitance_reg;
        end
    end
    assign range_shift_o = range_shift_reg;

    // ****************************************
    // Integration and strength
    // ****************************************
    assign integ_end = sense_tick_i &&
        (integ_cnt_reg + 8'h01 >= integration_length_reg || integration_length_reg == 8'h00);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            integ_cnt_reg <= 8'h00;
        end else if (integ_end) begin
            integ_cnt_reg <= 8'h00;
        end else if (sense_tick_i) begin
            integ_cnt_reg <= integ_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                channel_live_level_reg[i]   <= 8'h00;
                exceed_acc_reg[i]           <= 8'h00;
                channel_exceed_count_reg[i] <= 8'h00;
            end
        end else if (sense_tick_i) begin
            for (int i = 0; i < 8; i++) begin
                channel_live_level_reg[i] <= sense_level_i[i*8 +: 8];
                if (integ_end) begin
                    exceed_acc_reg[i] <= 8'h00;
                    channel_exceed_count_reg[i] <= exceed_acc_reg[i] +
                        8'(sense_level_i[i*8 +: 8] < channel_reference_level_reg[i] &&
                           exceed_acc_reg[i] < integration_length_reg);
                end else if (sense_level_i[i*8 +: 8] < channel_reference_level_reg[i] &&
                             exceed_acc_reg[i] < integration_length_reg) begin
                    exceed_acc_reg[i] <= exceed_acc_reg[i] + 8'h01;
                end
            end
        end
    end

    // ****************************************
    // Advanced filtering
    // ****************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            raw_touch[i] = channel_exceed_count_reg[i] >= channel_valid_touch_limit_reg[i];
        end
    end

    assign first_idx  = strongest(channel_exceed_count_reg, raw_touch);
    assign second_idx = strongest(channel_exceed_count_reg, raw_touch & ~(8'h01 << first_idx));

    always_comb begin
        afs_touch = 8'h00;
        unique case (filter_mode_t'(filter_mode_select_reg[`BIT_MODE_HI:`BIT_MODE_LO]))
            MODE_STRONGEST: begin
                afs_touch = (8'h01 << first_idx) & raw_touch;
            end
            MODE_TWO_BEST: begin
                afs_touch = ((8'h01 << first_idx) | (8'h01 << second_idx)) & raw_touch;
            end
            MODE_ALL_ABOVE, MODE_RESERVED: begin
                afs_touch = raw_touch;
            end
        endcase
    end

    // ****************************************
    // Second-level filter
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                filter_cnt_reg[i] <= 8'h00;
            end
        end else if (integ_end) begin
            for (int i = 0; i < 8; i++) begin
                filter_cnt_reg[i] <= 8'h00;
            end
        end else if (sense_tick_i && integ_cnt_reg < second_filter_samples_reg) begin
            for (int i = 0; i < 8; i++) begin
                if (afs_touch[i] && filter_cnt_reg[i] != 8'hFF)
                    filter_cnt_reg[i] <= filter_cnt_reg[i] + 8'h01;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            result_touch[i] = filter_mode_select_reg[`BIT_FILTER_EN] ?
                (filter_cnt_reg[i] > second_filter_limit_reg) : afs_touch[i];
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            touch_state_reg <= 8'h00;
        end else if (integ_end) begin
            touch_state_reg <= result_touch;
        end
    end
    assign touch_state_o = touch_state_reg;

    // ****************************************
    // Touch event FIFO
    // ****************************************
    assign fifo_push = integ_end && result_touch != touch_state_reg && fifo_cnt_reg != 3'h4;
    assign fifo_pop  = reg_req_i.rd && reg_req_i.addr == `OFS_FIFO_FIRST + 8'h01 &&
                       fifo_cnt_reg != 3'h0;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_wr_reg  <= 2'h0;
            fifo_rd_reg  <= 2'h0;
            fifo_cnt_reg <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                fifo_mem[i] <= 8'h00;
            end
        end else begin
            if (fifo_push) begin
                fifo_mem[fifo_wr_reg] <= result_touch;
                fifo_wr_reg <= fifo_wr_reg + 2'h1;
            end
            if (fifo_pop) begin
                fifo_rd_reg <= fifo_rd_reg + 2'h1;
            end
            fifo_cnt_reg <= fifo_cnt_reg + 3'(fifo_push) - 3'(fifo_pop);
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_irq_reg <= 1'b0;
        end else if (fifo_push) begin
            fifo_irq_reg <= 1'b1;
        end else if (fifo_irq_clear_i && fifo_cnt_reg == 3'h0) begin
            fifo_irq_reg <= 1'b0;
        end
    end
    assign fifo_irq_o = fifo_irq_reg;

    // ****************************************
    // Calibration timing
    // ****************************************
    assign no_touch       = raw_touch == 8'h00;
    assign wait_ticks     = 16'(recal_wait_time_reg) * `WAIT_MULT + `WAIT_ADD;
    assign interval_ticks = 16'(recal_interval_reg) * `INTERVAL_MULT;
    assign quiet_done     = quiet_cnt_reg >= wait_ticks;
    assign interval_done  = interval_cnt_reg >= interval_ticks;
    assign auto_cal       = !hold && quiet_done && interval_done;
    assign host_cal       = hold && (sense_control_reg[`BIT_HOST_UNCOND] ||
                            (sense_control_reg[`BIT_HOST_COND] && no_touch));

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            quiet_cnt_reg <= 16'h0000;
        end else if (!no_touch) begin
            quiet_cnt_reg <= 16'h0000;
        end else if (sense_tick_i && !quiet_done) begin
            quiet_cnt_reg <= quiet_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            interval_cnt_reg <= 16'h0000;
        end else if (cal_state_reg == CAL_DONE) begin
            interval_cnt_reg <= 16'h0000;
        end else if (sense_tick_i && !interval_done) begin
            interval_cnt_reg <= interval_cnt_reg + 16'h0001;
        end
    end

    always_comb begin
        cal_state_next = cal_state_reg;
        unique case (cal_state_reg)
            CAL_IDLE:    if (auto_cal || host_cal) cal_state_next = CAL_CAPTURE;
            CAL_CAPTURE: cal_state_next = CAL_DONE;
            CAL_DONE:    cal_state_next = CAL_IDLE;
            default:     cal_state_next = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cal_state_reg <= CAL_IDLE;
        end else begin
            cal_state_reg <= cal_state_next;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                channel_reference_level_reg[i] <= 8'h00;
            end
        end else if (cal_state_reg == CAL_CAPTURE) begin
            channel_reference_level_reg <= channel_live_level_reg;
        end
    end

    // ****************************************
    // End-of-calibration interrupt
    // ****************************************
    assign eoc_event = cal_state_reg == CAL_DONE;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            eoc_pending_reg <= 1'b0;
        end else if (eoc_event) begin
            eoc_pending_reg <= 1'b1;
        end else if (wr_hit(reg_req_i, `OFS_IRQ_CLEAR) && reg_req_i.wdata[`BIT_EOC]) begin
            eoc_pending_reg <= 1'b0;
        end
    end

    assign system_irq_group_o = eoc_pending_reg && !touch_irq_mask_reg[`BIT_EOC];
    assign low_power_o = !sense_control_reg[`BIT_FORCE_ACTIVE] && quiet_done &&
                         cal_state_reg == CAL_IDLE;

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_req_i.rd) begin
            reg_rdata_reg <= 8'h00;
            unique case (reg_req_i.addr)
                `OFS_FILTER_MODE:  reg_rdata_reg <= filter_mode_select_reg;
                `OFS_WAIT_TIME:    reg_rdata_reg <= recal_wait_time_reg;
                `OFS_INTERVAL:     reg_rdata_reg <= recal_interval_reg;
                `OFS_INTEGRATION:  reg_rdata_reg <= integration_length_reg;
                `OFS_SENSE_CTRL:   reg_rdata_reg <= sense_control_reg;
                `OFS_IRQ_MASK:     reg_rdata_reg <= touch_irq_mask_reg;
                `OFS_IRQ_CLEAR:    reg_rdata_reg <= touch_irq_clear_reg;
                `OFS_FILT_SAMPLES: reg_rdata_reg <= second_filter_samples_reg;
                `OFS_FILT_LIMIT:   reg_rdata_reg <= second_filter_limit_reg;
                `OFS_RANGE_SHIFT:  reg_rdata_reg <= {1'b0, range_shift_capacitance_reg};
                `OFS_AMBIENT_VAR:  reg_rdata_reg <= {1'b0, ambient_variance_reg};
                `OFS_IRQ_PENDING:  reg_rdata_reg <= {4'h0, eoc_pending_reg, 3'h0};
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (reg_req_i.addr == `OFS_FIFO_FIRST + 8'(2*k) &&
                            fifo_cnt_reg > 3'(k))
                            reg_rdata_reg <= fifo_mem[fifo_rd_reg + 2'(k)];
                    end
                    for (int i = 0; i < 8; i++) begin
                        if (reg_req_i.addr == `OFS_VARIANCE_BASE + 8'(i))
                            reg_rdata_reg <= {1'b0, channel_touch_variance_reg[i]};
                        if (reg_req_i.addr == `OFS_LIMIT_BASE + 8'(i))
                            reg_rdata_reg <= channel_valid_touch_limit_reg[i];
                        if (reg_req_i.addr == `OFS_EXCEED_BASE + 8'(i))
                            reg_rdata_reg <= channel_exceed_count_reg[i];
                        if (reg_req_i.addr == `OFS_REF_BASE + 8'(i))
                            reg_rdata_reg <= channel_reference_level_reg[i];
                        if (reg_req_i.addr == `OFS_LIVE_BASE + 8'(i))
                            reg_rdata_reg <= channel_live_level_reg[i];
                    end
                end
            endcase
        end
    end
    assign reg_rdata_o = reg_rdata_reg;
endmodule

// ### logic/touch_key_consts.svh
`ifndef TOUCH_KEY_CONSTS_SVH
`define TOUCH_KEY_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_FIFO_FIRST     8'h18
`define OFS_FIFO_LAST      8'h1F
`define OFS_FILTER_MODE    8'h20
`define OFS_WAIT_TIME      8'h21
`define OFS_INTERVAL       8'h22
`define OFS_INTEGRATION    8'h23
`define OFS_SENSE_CTRL     8'h25
`define OFS_IRQ_MASK       8'h26
`define OFS_IRQ_CLEAR      8'h27
`define OFS_FILT_SAMPLES   8'h28
`define OFS_FILT_LIMIT     8'h29
`define OFS_RANGE_SHIFT    8'h2A
`define OFS_VARIANCE_BASE  8'h30
`define OFS_AMBIENT_VAR    8'h40
`define OFS_LIMIT_BASE     8'h50
`define OFS_EXCEED_BASE    8'h60
`define OFS_REF_BASE       8'h70
`define OFS_LIVE_BASE      8'h80
`define OFS_IRQ_PENDING    8'h92
// ****************************************
// Field positions
// ****************************************
`define BIT_FILTER_EN      0
`define BIT_MODE_LO        1
`define BIT_MODE_HI        2
`define BIT_HOLD           0
`define BIT_HOST_COND      1
`define BIT_HOST_UNCOND    2
`define BIT_FORCE_ACTIVE   3
`define BIT_EOC            3
// ****************************************
// Reset values
// ****************************************
`define RST_FILTER_MODE    8'h04
`define RST_WAIT_TIME      8'h27
`define RST_INTERVAL       8'h30
`define RST_INTEGRATION    8'h0F
`define RST_IRQ_MASK       8'h08
`define RST_VARIANCE       7'h08
`define RST_AMBIENT_VAR    7'h04
`define RST_LIMIT          8'h01
`define RST_ZERO           8'h00
// ****************************************
// Timing counts, in sensor clock periods
// ****************************************
`define WAIT_MULT          16'h0040
`define WAIT_ADD           16'h0001
`define INTERVAL_MULT      16'h0032
`endif

// ### logic/touch_key_pkg.sv
package touch_key_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        MODE_RESERVED  = 2'h0,
        MODE_STRONGEST = 2'h1,
        MODE_ALL_ABOVE = 2'h2,
        MODE_TWO_BEST  = 2'h3
    } filter_mode_t;

    typedef enum logic [2:0] {
        CAL_IDLE    = 3'b001,
        CAL_CAPTURE = 3'b010,
        CAL_DONE    = 3'b100
    } cal_state_t;

    typedef logic [7:0] chan_byte_t [8];
endpackage

// ### verif/touch_key_chk.sv
`timescale 1ns/1ps
module touch_key_chk
    import touch_key_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire reg_req_t   reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       sense_tick_i,
    input wire logic       warm_rst_i,
    input wire logic       fifo_irq_clear_i,
    input wire logic       fifo_irq_o,
    input wire logic       system_irq_group_o,
    input wire logic       low_power_o,
    input wire logic [6:0] range_shift_o,
    input wire logic [7:0] touch_state_o
);
    logic       f2a_reg, hold_reg, msk_reg;
    logic [6:0] rs_reg;
    wire  [7:0] a = reg_req_i.addr;
    wire  [7:0] d = reg_req_i.wdata;
    // Mirror of written control bits
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {f2a_reg, hold_reg, msk_reg, rs_reg} <= 10'h080;
        end else if (reg_req_i.wr) begin
            if (a == 8'h25) {f2a_reg, hold_reg} <= {d[3], d[0]};
            if (a == 8'h26) msk_reg <= d[3];
            if (a == 8'h2A) rs_reg <= d[6:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    chk_force_active: assert property (f2a_reg |-> !low_power_o)
        else $error("low power while forced active");
    chk_eoc_masked: assert property (msk_reg |-> !system_irq_group_o)
        else $error("masked eoc reached group");
    chk_eoc_clear: assert property (reg_req_i.wr && a == 8'h27 && d[3] && hold_reg
        |=> !system_irq_group_o) else $error("eoc not cleared");
    chk_pending_read: assert property (reg_req_i.rd && a == 8'h92 && !msk_reg
        |=> reg_rdata_o == {4'h0, $past(system_irq_group_o), 3'h0}) else $error("pending");
    chk_warm_load: assert property (warm_rst_i |=> range_shift_o == $past(rs_reg))
        else $error("range shift not loaded");
    chk_shift_hold: assert property (!warm_rst_i |=> $stable(range_shift_o))
        else $error("range shift moved");
    chk_fifo_irq_sticky: assert property (fifo_irq_o && !fifo_irq_clear_i |=> fifo_irq_o)
        else $error("fifo irq dropped");
    chk_state_on_tick: assert property (!sense_tick_i |=> $stable(touch_state_o))
        else $error("touch state moved without tick");
    cover property (system_irq_group_o);
    cover property (fifo_irq_o && fifo_irq_clear_i);
    cover property (warm_rst_i);
endmodule
bind touch_key_sense_control touch_key_chk i_touch_key_chk (.*);

// ### verif/sense_front_model.sv
`timescale 1ns/1ps
module sense_front_model (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic [63:0] lvl_i,
    output logic             tick_o,
    output logic [63:0]      level_o
);
    // One sample strobe each period with its levels
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) {tick_o, level_o} <= 65'h0;
        else {tick_o, level_o} <= {1'b1, lvl_i};
    end
endmodule

// ### verif/touch_key_sense_control_tb.sv
`timescale 1ns/1ps
module touch_key_sense_control_tb;
    import touch_key_pkg::*;
    logic        clock_i, sys_rst_i, warm_rst_i, fifo_irq_clear_i, tick, irq_f, irq_g, lp;
    logic [63:0] lvl, level;
    logic [7:0]  rdata, state;
    logic [6:0]  rs;
    reg_req_t    req;
    int          fail_count, check_count;
    logic [15:0] rows [10] = '{16'h2004, 16'h2127, 16'h2230, 16'h230F, 16'h2500,
                               16'h2608, 16'h3008, 16'h4004, 16'h5001, 16'h6000};
    touch_key_sense_control i_touch_key_sense_control (.clock_i, .sys_rst_i,
        .reg_req_i(req), .reg_rdata_o(rdata), .sense_tick_i(tick), .sense_level_i(level),
        .warm_rst_i, .fifo_irq_clear_i, .fifo_irq_o(irq_f), .system_irq_group_o(irq_g),
        .low_power_o(lp), .range_shift_o(rs), .touch_state_o(state));
    sense_front_model i_sense_front_model (.clock_i, .sys_rst_i, .lvl_i(lvl), .tick_o(tick),
        .level_o(level));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic cmp(input logic [7:0] g, e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, dat);
        req = '{w, !w, a, dat};
        @(posedge clock_i) #1 req = '0;
        @(posedge clock_i) #1;
    endtask
    task automatic rd(input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        cmp(rdata, e);
    endtask
    task automatic wait_sig(input bit k);
        int n;
        for (n = 0; n < 200 && (k ? irq_f : irq_g) !== 1'b1; n++) @(posedge clock_i) #1;
        if (n == 200) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        {sys_rst_i, warm_rst_i, fifo_irq_clear_i, req, fail_count, check_count} = '0;
        sys_rst_i = 1'b1;
        for (int i = 0; i < 8; i++) lvl[8*i+:8] = 8'h40 + 8'(i);
        repeat (4) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h20, 8'(2*m) | 8'hF8);
            rd(8'h20, 8'(2*m));
        end
        bus(1'b1, 8'h20, 8'h04);
        bus(1'b1, 8'h92, 8'hFF);
        rd(8'h92, 8'h00);
        bus(1'b1, 8'h30, 8'h63);
        rd(8'h30, 8'h63);
        $display("register test done");
        bus(1'b1, 8'h25, 8'h01);
        bus(1'b1, 8'h26, 8'h00);
        bus(1'b1, 8'h25, 8'h05);
        wait_sig(1'b0);
        rd(8'h25, 8'h01);
        rd(8'h92, 8'h08);
        bus(1'b1, 8'h27, 8'h08);
        rd(8'h92, 8'h00);
        for (int i = 0; i < 8; i++) rd(8'h70 + 8'(i), 8'h40 + 8'(i));
        for (int i = 0; i < 8; i++) rd(8'h80 + 8'(i), 8'h40 + 8'(i));
        $display("calibration test done");
        lvl[7:0] = 8'h10;
        lvl[23:16] = 8'h10;
        wait_sig(1'b1);
        cmp(state, 8'h05);
        rd(8'h60, 8'h0F);
        rd(8'h18, 8'h05);
        rd(8'h19, 8'h00);
        fifo_irq_clear_i = 1'b1;
        @(posedge clock_i) #1 fifo_irq_clear_i = 1'b0;
        cmp({7'h0, irq_f}, 8'h00);
        bus(1'b1, 8'h25, 8'h03);
        repeat (4) @(posedge clock_i) #1;
        rd(8'h25, 8'h03);
        bus(1'b1, 8'h2A, 8'hFF);
        warm_rst_i = 1'b1;
        @(posedge clock_i) #1 warm_rst_i = 1'b0;
        cmp({1'b0, rs}, 8'h7F);
        bus(1'b1, 8'h25, 8'h09);
        cmp({7'h0, lp}, 8'h00);
        for (int i = 0; i < 8; i++) lvl[8*i+:8] = 8'h40 + 8'(i);
        repeat (2600) @(posedge clock_i) #1;
        cmp({7'h0, lp}, 8'h00);
        bus(1'b1, 8'h25, 8'h01);
        cmp({7'h0, lp}, 8'h01);
        $display("touch test done");
        final_report();
    end
endmodule
